// ===== isq_map.vh
`ifndef ISQ_MAP_VH
`define ISQ_MAP_VH
// register offsets
`define ISQ_ADDR_EVENT_EN   8'h16
`define ISQ_ADDR_MISC       8'h17
`define ISQ_ADDR_SYS_OPT    8'h35
`define ISQ_ADDR_CORE_CTL   8'h3e
`define ISQ_ADDR_CORE_STAT  8'h3f
// field positions
`define ISQ_BIT_EN_ONE      6
`define ISQ_BIT_EN_TWO      5
`define ISQ_BIT_FLAG_ONE    6
`define ISQ_BIT_FLAG_TWO    5
`define ISQ_BIT_KEY_FLAG    4
`define ISQ_BIT_SEL_ONE     4
`define ISQ_BIT_SEL_TWO     3
// reset values
`define ISQ_RST_EVENT_EN    8'h00
`define ISQ_RST_MISC        8'h00
`define ISQ_RST_SYS_OPT     8'h00
// vectors, low byte address of each pair
`define ISQ_VEC_RESET       16'hfffe
`define ISQ_VEC_TRAP        16'hfffc
`define ISQ_VEC_EXT         16'hfffa
`define ISQ_VEC_TMRB        16'hfff8
`define ISQ_VEC_TMRA        16'hfff6
`define ISQ_VEC_SERIAL      16'hfff4
`define ISQ_VEC_LINE        16'hfff2
`define ISQ_VEC_KEY         16'hfff0
// timing counts
`define ISQ_SYNC_STAGES     2
`endif

// ===== isq_sync.v
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser for one asynchronous pin
module isq_sync (
   input  wire ref_clk,
   input  wire rst,
   input  wire async_in,
   output wire sync_out
);
   reg meta_q;
   reg sync_q;
   // reset to high: request pins idle high
   always @(posedge ref_clk) begin
      if (rst) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
   assign sync_out = sync_q;
endmodule // isq_sync
`default_nettype wire

// ===== isq_ext_line.v
`timescale 1ns/1ns
`default_nettype none
// one external request line: edge detect, latch, flag
module isq_ext_line (
   input  wire ref_clk,
   input  wire rst,
   input  wire line_sync,
   input  wire edge_only,
   input  wire enable,
   input  wire latch_clr,
   input  wire flag_clr,
   output wire flag,
   output wire req
);
   reg prev_q;
   reg latch_q;
   reg flag_q;
   wire fall;
   wire trig;
   assign fall = prev_q & ~line_sync;
   assign trig = fall | (~edge_only & ~line_sync);
   always @(posedge ref_clk) begin
      if (rst) begin
         prev_q  <= 1'b1;
         latch_q <= 1'b0;
         flag_q  <= 1'b0;
      end else begin
         prev_q <= line_sync;
         // one pulse kept
         // level would re-set it and defeat the early clear
         // edges only latch
         if (fall)
            latch_q <= 1'b1;
         else if (latch_clr)
            latch_q <= 1'b0;
         if (trig)
            flag_q <= 1'b1;
         else if (flag_clr)
            flag_q <= 1'b0;
      end
   end
   assign flag = flag_q;
   assign req  = latch_q & enable;
endmodule // isq_ext_line
`default_nettype wire

// ===== isq_sequencer.v
// Contract
// - reset pin fetches start address from vector pair fffe/ffff, defaults state
// - reset sets the interrupt mask bit
// - stop halts oscillator until external, keypad interrupt or reset
// - wait stops cpu clocks, peripherals run; exits on listed interrupts
// - wake from wait uses the interrupt's normal vector
// - software trap ignores the mask and uses vector fffc/fffd
// - trigger select bits at system option bits four and three
// - trigger sets the line flag; interrupt only when mask clear; shared vector
// - recognition stacks state and sets the mask bit
// - falling transitions and short low pulses are detected
// - edge and level mode re-requests while line stays low
// - latch clears early in service; one further pulse kept
// - four line-code sources share vector fff2/fff3
// - select one gives edge only, zero gives level and edge
// - enable bit per line in event enable register
// - flag reads one when a request occurred
// - cleared enable blocks the request, not the flag
`timescale 1ns/1ns
`default_nettype none
`include "isq_map.vh"
module isq_sequencer (
   input  wire        ref_clk,
   input  wire        rst,
   input  wire        ext_request_line_one_n,
   input  wire        ext_request_line_two_n,
   input  wire [7:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata,
   input  wire        software_trap,
   input  wire        stop_exec,
   input  wire        wait_exec,
   input  wire        return_from_interrupt,
   input  wire        stacked_mask,
   input  wire        insn_boundary,
   input  wire        stack_done,
   input  wire        timer_b_underflow_flag,
   input  wire        capture_event_flag,
   input  wire        compare_match_flag,
   input  wire        counter_wrap_flag,
   input  wire        serial_done_flag,
   input  wire        encoder_reg_empty_flag,
   input  wire        encoder_done_flag,
   input  wire        decoder_reg_full_flag,
   input  wire        decoder_overrun_flag,
   input  wire        keypad_event_flag,
   output reg         mask_bit,
   output reg         stack_req,
   output reg  [15:0] vector_addr,
   output reg         vector_valid,
   output reg         osc_run,
   output reg         cpu_clk_en,
   output reg         periph_clk_en
);
   localparam ST_RUN   = 5'b00001;
   localparam ST_STACK = 5'b00010;
   localparam ST_WAIT  = 5'b00100;
   localparam ST_STOP  = 5'b01000;
   localparam ST_RESET = 5'b10000;

   reg  [4:0]  state_q;
   reg  [7:0]  event_en_q;
   reg  [7:0]  sys_opt_q;
   reg  [15:0] vec_d;
   reg         trap_pend_q;
   reg         reset_svc_q;
   wire        line_one_s;
   wire        line_two_s;
   wire        flag_one;
   wire        flag_two;
   wire        req_one;
   wire        req_two;
   wire        ext_req;
   wire        tmra_req;
   wire        line_req;
   wire        any_hw;
   wire        stop_wake;
   wire        wait_wake;
   wire        latch_clr;
   wire        clr_one;
   wire        clr_two;

   isq_sync u_sync_one (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .async_in (ext_request_line_one_n),
      .sync_out (line_one_s)
   );
   isq_sync u_sync_two (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .async_in (ext_request_line_two_n),
      .sync_out (line_two_s)
   );

   assign latch_clr = (state_q == ST_STACK) & stack_done & (vec_d == `ISQ_VEC_EXT);
   assign clr_one = reg_wr & (reg_addr == `ISQ_ADDR_MISC) & ~reg_wdata[`ISQ_BIT_FLAG_ONE];
   assign clr_two = reg_wr & (reg_addr == `ISQ_ADDR_MISC) & ~reg_wdata[`ISQ_BIT_FLAG_TWO];

   isq_ext_line u_line_one (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .line_sync (line_one_s),
      .edge_only (sys_opt_q[`ISQ_BIT_SEL_ONE]),
      .enable    (event_en_q[`ISQ_BIT_EN_ONE]),
      .latch_clr (latch_clr),
      .flag_clr  (clr_one),
      .flag      (flag_one),
      .req       (req_one)
   );
   isq_ext_line u_line_two (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .line_sync (line_two_s),
      .edge_only (sys_opt_q[`ISQ_BIT_SEL_TWO]),
      .enable    (event_en_q[`ISQ_BIT_EN_TWO]),
      .latch_clr (latch_clr),
      .flag_clr  (clr_two),
      .flag      (flag_two),
      .req       (req_two)
   );

   assign ext_req  = req_one | req_two | (flag_one & event_en_q[`ISQ_BIT_EN_ONE])
                     | (flag_two & event_en_q[`ISQ_BIT_EN_TWO]);
   assign tmra_req = capture_event_flag | compare_match_flag | counter_wrap_flag;
   assign line_req = encoder_reg_empty_flag | encoder_done_flag
                     | decoder_reg_full_flag | decoder_overrun_flag;
   assign any_hw   = ext_req | timer_b_underflow_flag | tmra_req | serial_done_flag
                     | line_req | keypad_event_flag;
   assign stop_wake = ext_req | keypad_event_flag;
   assign wait_wake = any_hw;

   always @* begin
      if (reset_svc_q)
         vec_d = `ISQ_VEC_RESET;
      else if (trap_pend_q)
         vec_d = `ISQ_VEC_TRAP;
      else if (ext_req)
         vec_d = `ISQ_VEC_EXT;
      else if (timer_b_underflow_flag)
         vec_d = `ISQ_VEC_TMRB;
      else if (tmra_req)
         vec_d = `ISQ_VEC_TMRA;
      else if (serial_done_flag)
         vec_d = `ISQ_VEC_SERIAL;
      else if (line_req)
         vec_d = `ISQ_VEC_LINE;
      else
         vec_d = `ISQ_VEC_KEY;
   end

   // register writes
   always @(posedge ref_clk) begin
      if (rst) begin
         event_en_q <= `ISQ_RST_EVENT_EN;
         sys_opt_q  <= `ISQ_RST_SYS_OPT;
      end else if (reg_wr) begin
         if (reg_addr == `ISQ_ADDR_EVENT_EN)
            event_en_q <= reg_wdata;
         else if (reg_addr == `ISQ_ADDR_SYS_OPT)
            sys_opt_q <= reg_wdata;
      end
   end

   // read path, one cycle latency
   always @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == `ISQ_ADDR_EVENT_EN)
            reg_rdata <= {1'b0, event_en_q[6:5], 5'h00};
         else if (reg_addr == `ISQ_ADDR_MISC)
            reg_rdata <= {1'b0, flag_one, flag_two, keypad_event_flag, 4'h0};
         else if (reg_addr == `ISQ_ADDR_SYS_OPT)
            reg_rdata <= {1'b0, sys_opt_q[6:3], 3'h0};
         else if (reg_addr == `ISQ_ADDR_CORE_STAT)
            reg_rdata <= {2'h0, mask_bit, state_q};
         else
            reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // sequencer
   always @(posedge ref_clk) begin
      if (rst) begin
         state_q       <= ST_RESET;
         mask_bit      <= 1'b1;
         reset_svc_q   <= 1'b1;
         trap_pend_q   <= 1'b0;
         stack_req     <= 1'b0;
         vector_addr   <= `ISQ_VEC_RESET;
         vector_valid  <= 1'b0;
         osc_run       <= 1'b1;
         cpu_clk_en    <= 1'b1;
         periph_clk_en <= 1'b1;
      end else begin
         vector_valid <= 1'b0;
         if (software_trap)
            trap_pend_q <= 1'b1;
         if (return_from_interrupt)
            mask_bit <= stacked_mask;
         case (state_q)
            ST_RESET: begin
               vector_addr  <= `ISQ_VEC_RESET;
               vector_valid <= 1'b1;
               reset_svc_q  <= 1'b0;
               state_q      <= ST_RUN;
            end
            ST_RUN: begin
               if (insn_boundary & (trap_pend_q | software_trap |
                                    (any_hw & ~mask_bit))) begin
                  stack_req <= 1'b1;
                  state_q   <= ST_STACK;
               end else if (stop_exec) begin
                  osc_run       <= 1'b0;
                  cpu_clk_en    <= 1'b0;
                  periph_clk_en <= 1'b0;
                  mask_bit      <= 1'b0;
                  state_q       <= ST_STOP;
               end else if (wait_exec) begin
                  cpu_clk_en <= 1'b0;
                  mask_bit   <= 1'b0;
                  state_q    <= ST_WAIT;
               end
            end
            ST_STACK: begin
               if (stack_done) begin
                  stack_req    <= 1'b0;
                  mask_bit     <= 1'b1;
                  vector_addr  <= trap_pend_q ? `ISQ_VEC_TRAP : vec_d;
                  vector_valid <= 1'b1;
                  trap_pend_q  <= 1'b0;
                  state_q      <= ST_RUN;
               end
            end
            ST_WAIT: begin
               if (wait_wake) begin
                  cpu_clk_en <= 1'b1;
                  stack_req  <= 1'b1;
                  state_q    <= ST_STACK;
               end
            end
            ST_STOP: begin
               if (stop_wake) begin
                  osc_run       <= 1'b1;
                  cpu_clk_en    <= 1'b1;
                  periph_clk_en <= 1'b1;
                  stack_req     <= 1'b1;
                  state_q       <= ST_STACK;
               end
            end
            default: state_q <= ST_RESET;
         endcase
      end
   end
endmodule // isq_sequencer
`default_nettype wire

// ===== isq_seq_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module isq_seq_asserts (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        software_trap,
   input wire logic        stop_exec,
   input wire logic        wait_exec,
   input wire logic        insn_boundary,
   input wire logic        stack_done,
   input wire logic        mask_bit,
   input wire logic        stack_req,
   input wire logic [15:0] vector_addr,
   input wire logic        vector_valid,
   input wire logic        osc_run,
   input wire logic        cpu_clk_en,
   input wire logic        periph_clk_en
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   AST_RST_MASK: assert property ($fell(rst) |-> mask_bit [*2])
      else $error("mask bit clear after reset");
   AST_RST_VEC: assert property ($fell(rst) |-> ##[0:1]
      (vector_valid && vector_addr == 16'hfffe)) else $error("no reset vector");
   AST_TRAP_TAKE: assert property (
      software_trap && insn_boundary && cpu_clk_en && !stack_req |=> stack_req)
      else $error("trap not taken");
   // a hardware take must have seen the mask clear one cycle before
   AST_MASK_GATE: assert property (
      $rose(stack_req) |-> $past(software_trap) || !$past(mask_bit))
      else $error("interrupt taken while masked");
   AST_STACK_VEC: assert property (
      stack_req && stack_done |=> vector_valid && mask_bit && !stack_req)
      else $error("vector or mask missing after stacking");
   AST_VEC_PAIR: assert property (
      vector_valid |-> vector_addr[15:4] == 12'hfff && !vector_addr[0])
      else $error("vector outside table");
   AST_STOP_OSC: assert property (stop_exec && insn_boundary |-> ##[1:2] !osc_run)
      else $error("oscillator still running");
   AST_WAIT_CLK: assert property (
      wait_exec |-> ##[1:2] (!cpu_clk_en && periph_clk_en))
      else $error("wait clocks wrong");
   AST_RD_IDLE: assert property (
      !(reg_rd && reg_addr inside {8'h16, 8'h17, 8'h35, 8'h3f}) |=> reg_rdata == 8'h00)
      else $error("read data not zero");
   COV_TRAP: cover property (vector_valid && vector_addr == 16'hfffc);
   COV_EXT: cover property (vector_valid && vector_addr == 16'hfffa);
   COV_WAKE: cover property (!osc_run ##[1:60] vector_valid);
endmodule // isq_seq_asserts
bind isq_sequencer isq_seq_asserts chk_u (.*);
`default_nettype wire

// ===== isq_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// core side of stacking; slow stretches the push to expose latency bugs
module isq_core_model (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic stack_req,
   input  wire logic slow,
   output var  logic stack_done
);
   logic [3:0] left_q;
   always @(posedge ref_clk) begin
      if (rst || !stack_req || stack_done) begin
         left_q <= slow ? 4'h9 : 4'h1;
         stack_done <= 1'b0;
      end else begin
         left_q <= left_q - 4'h1;
         stack_done <= (left_q == 4'h1);
      end
   end
endmodule // isq_core_model
`default_nettype wire

// ===== interrupt_sequencer_ext_irq_bench.sv
`timescale 1ns/1ns
`default_nettype none
module interrupt_sequencer_ext_irq_bench;
   logic        ref_clk, rst, reg_wr, reg_rd, stacked_mask, insn_boundary, slow;
   logic        stack_done, mask_bit, stack_req, vector_valid, osc_run, cpu_clk_en, periph_clk_en;
   logic [1:0]  ln;
   logic [5:0]  op;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_v;
   logic [9:0]  pf;
   logic [15:0] vector_addr;
   int          num_errors = 0;
   int          checks = 0;

   isq_sequencer dut_u (.*,
      .ext_request_line_one_n(!(ln[0] | op[4])), .ext_request_line_two_n(!(ln[1] | op[5])),
      .software_trap(op[0]), .wait_exec(op[1]), .stop_exec(op[2]),
      .return_from_interrupt(op[3]), .timer_b_underflow_flag(pf[0]),
      .capture_event_flag(pf[1]), .compare_match_flag(pf[2]), .counter_wrap_flag(pf[3]),
      .serial_done_flag(pf[4]), .encoder_reg_empty_flag(pf[5]), .encoder_done_flag(pf[6]),
      .decoder_reg_full_flag(pf[7]), .decoder_overrun_flag(pf[8]), .keypad_event_flag(pf[9]));
   isq_core_model core_u (.ref_clk, .rst, .stack_req, .slow, .stack_done);

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic tally_and_finish;
      if (num_errors == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one strobe; read data lands in the cycle after
   task automatic bus(input logic w, input logic [7:0] a, d);
      @(posedge ref_clk);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
      @(posedge ref_clk);
      {reg_wr, reg_rd} <= 2'b00;
      #1 rd_v = reg_rdata;
   endtask

   task automatic pulse(input logic [5:0] v);
      @(posedge ref_clk);
      op <= v;
      @(posedge ref_clk);
      op <= 6'h00;
   endtask

   // e of zero means no vector may appear in the window
   task automatic take(input logic [15:0] e);
      logic [15:0] got;
      got = 16'h0000;
      slow <= 1'($urandom);
      for (int n = 0; n < 60 && got === 16'h0000; n++) begin
         @(posedge ref_clk);
         #1 if (vector_valid === 1'b1) got = vector_addr;
      end
      chk("vector", e, got);
      if (e != 16'h0000 && got === 16'h0000)
         tally_and_finish();
   endtask

   function automatic logic [15:0] vec_of(input logic [9:0] f);
      if (f[0]) return 16'hfff8;
      if (|f[3:1]) return 16'hfff6;
      if (f[4]) return 16'hfff4;
      if (|f[8:5]) return 16'hfff2;
      return 16'hfff0;
   endfunction

   initial begin
      void'($urandom(32'h6a0fc48b));
      {rst, reg_wr, reg_rd, stacked_mask, insn_boundary, slow} = 6'b100010;
      {ln, op, pf, reg_addr, reg_wdata} = '0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      take(16'hfffe);
      chk("mask", 1, mask_bit);
      for (int i = 0; i < 4; i++) begin
         bus(0, 8'(32'h3e351716 >> 8 * i), 8'h00);
         chk("reset value", 0, rd_v);
      end
      pulse(6'h01);
      take(16'hfffc);
      for (int i = 0; i < 18; i++) begin
         pf <= (i < 10) ? 10'h001 << i : 10'($urandom_range(1023, 1));
         pulse(6'h08);
         take(vec_of(pf));
      end
      pf <= 10'h000;
      bus(1, 8'h16, 8'h60);
      ln <= 2'b01;
      pulse(6'h08);
      take(16'hfffa);
      chk("mask", 1, mask_bit);
      bus(0, 8'h17, 8'h00);
      chk("flag one", 1, rd_v[6]);
      bus(1, 8'h17, 8'h00);
      pulse(6'h08);
      take(16'hfffa);
      ln <= 2'b00;
      // let the released level pass the synchroniser first
      repeat (4) @(posedge ref_clk);
      bus(1, 8'h17, 8'h00);
      pulse(6'h08);
      take(16'h0000);
      bus(1, 8'h35, 8'h18);
      ln <= 2'b10;
      pulse(6'h08);
      take(16'hfffa);
      bus(1, 8'h17, 8'h00);
      pulse(6'h08);
      take(16'h0000);
      ln <= 2'b00;
      pulse(6'h20);
      take(16'hfffa);
      bus(1, 8'h17, 8'h00);
      pulse(6'h20);
      pulse(6'h08);
      take(16'hfffa);
      bus(1, 8'h17, 8'h00);
      pulse(6'h08);
      take(16'h0000);
      bus(1, 8'h16, 8'h00);
      pulse(6'h10);
      take(16'h0000);
      bus(0, 8'h17, 8'h00);
      chk("flag one", 1, rd_v[6]);
      bus(1, 8'h17, 8'h00);
      // edge latched while disabled is taken once enabled
      bus(1, 8'h16, 8'h40);
      take(16'hfffa);
      pulse(6'h02);
      @(posedge ref_clk);
      #1 chk("cpu clock", 0, cpu_clk_en);
      chk("periph clock", 1, periph_clk_en);
      pf <= 10'h008;
      take(16'hfff6);
      chk("cpu clock", 1, cpu_clk_en);
      pf <= 10'h000;
      bus(1, 8'h16, 8'h40);
      pulse(6'h04);
      pf <= 10'h001;
      take(16'h0000);
      chk("oscillator", 0, osc_run);
      pulse(6'h10);
      take(16'hfffa);
      chk("oscillator", 1, osc_run);
      tally_and_finish();
   end
endmodule // interrupt_sequencer_ext_irq_bench
`default_nettype wire
